// File: design/stxe_pkg.sv
// Shared constants and carriers for the skip, table-read and exclusive-or execute unit.
// Assumes a host core that decodes opcodes into the operation codes below.
package stxe_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PAGE_W = 8;
  localparam int unsigned PC_W = 12;
  localparam int unsigned PROG_W = 15;
  localparam int unsigned HIGH_W = PROG_W - DATA_W;
  localparam int unsigned BIT_SEL_W = 3;
  localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
  localparam logic [HIGH_W-1:0] HIGH_RST = 7'h00;
  localparam logic [PC_W-PAGE_W-1:0] LAST_PAGE = 4'hf;
  localparam int unsigned SKIP_CYCLES = 2;
  localparam int unsigned NOSKIP_CYCLES = 1;

  typedef enum logic [3:0] {
    STXE_OP_NONE,
    STXE_OP_NIBBLE_EXCHANGE_TO_WORK,
    STXE_OP_SKIP_WHEN_NULL,
    STXE_OP_MOVE_SKIP_WHEN_NULL,
    STXE_OP_SKIP_BIT_NULL,
    STXE_OP_TABLE_READ_CURRENT_PAGE,
    STXE_OP_TABLE_READ_LAST_PAGE,
    STXE_OP_XOR_TO_WORK,
    STXE_OP_BITWISE_DIFFERENCE_TO_MEMORY,
    STXE_OP_XOR_IMMEDIATE
  } stxe_op_e;

  // One issued instruction with its operands
  typedef struct packed {
    stxe_op_e op;
    logic [DATA_W-1:0] mem_data;
    logic [DATA_W-1:0] imm;
    logic [BIT_SEL_W-1:0] bit_sel;
    logic [PC_W-1:0] pc;
  } stxe_issue_s;

  // Status flags; only zero is owned by this unit
  typedef struct packed {
    logic timeout;
    logic power_down;
    logic overflow;
    logic zero;
    logic aux_carry;
    logic carry;
  } stxe_flags_s;

  localparam stxe_flags_s FLAGS_RST = 6'h00;
endpackage

// File: design/stxe_exec.sv
// Execute unit for null-skip, table-read and exclusive-or instructions.
// Assumes one issue per machine cycle on CLK_I, memory operand already read,
// and a program memory that answers PROG_ADDR_O within the same cycle.
`timescale 1ns/1ps

module stxe_exec (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic ISSUE_VALID_I,
  input wire stxe_pkg::stxe_issue_s ISSUE_I,
  input wire logic [stxe_pkg::PAGE_W-1:0] TABLE_POINTER_I,
  input wire logic [stxe_pkg::PROG_W-1:0] PROG_DATA_I,
  output logic [stxe_pkg::PC_W-1:0] PROG_ADDR_O,
  output logic [stxe_pkg::DATA_W-1:0] WORK_O,
  output logic [stxe_pkg::HIGH_W-1:0] TABLE_HIGH_LATCH_O,
  output stxe_pkg::stxe_flags_s FLAGS_O,
  output logic MEM_WE_O,
  output logic [stxe_pkg::DATA_W-1:0] MEM_WDATA_O,
  output logic DISCARD_O,
  output logic BUSY_O
);

  function automatic logic is_null(input logic [stxe_pkg::DATA_W-1:0] v);
    is_null = (v == '0);
  endfunction

  function automatic logic is_table_read(input stxe_pkg::stxe_op_e op);
    is_table_read = (op == stxe_pkg::STXE_OP_TABLE_READ_CURRENT_PAGE)
                    || (op == stxe_pkg::STXE_OP_TABLE_READ_LAST_PAGE);
  endfunction

  logic [stxe_pkg::DATA_W-1:0] work_ff, nxt_work;
  logic [stxe_pkg::HIGH_W-1:0] high_ff, nxt_high;
  stxe_pkg::stxe_flags_s flags_ff, nxt_flags;
  logic mem_we_ff, nxt_mem_we;
  logic [stxe_pkg::DATA_W-1:0] mem_wdata_ff, nxt_mem_wdata;
  logic discard_ff, nxt_discard;
  logic fetch_ff, nxt_fetch;
  logic busy_ff, nxt_busy;
  logic [stxe_pkg::PC_W-1:0] prog_addr_ff, nxt_prog_addr;
  logic [stxe_pkg::DATA_W-1:0] xres;
  logic skip;
  logic issue_ok;

  // Issue during the dummy cycle is the discarded prefetch and is ignored;
  // issue during a table fetch is not taken either, so the core must hold it
  assign issue_ok = ISSUE_VALID_I && !discard_ff && !fetch_ff;

  // Address group. The address leaves through a flop, so the program word only
  // comes back in the following cycle: a table read costs a second, fetch cycle.
  always_comb begin
    nxt_prog_addr = prog_addr_ff;
    if (issue_ok && ISSUE_I.op == stxe_pkg::STXE_OP_TABLE_READ_CURRENT_PAGE) begin
      nxt_prog_addr = {ISSUE_I.pc[stxe_pkg::PC_W-1:stxe_pkg::PAGE_W],
                       TABLE_POINTER_I};
    end else if (issue_ok && ISSUE_I.op == stxe_pkg::STXE_OP_TABLE_READ_LAST_PAGE) begin
      nxt_prog_addr = {stxe_pkg::LAST_PAGE, TABLE_POINTER_I};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      prog_addr_ff <= '0;
    end else if (CE_I) begin
      prog_addr_ff <= nxt_prog_addr;
    end
  end

  always_comb begin
    nxt_work = work_ff;
    nxt_high = high_ff;
    nxt_flags = flags_ff;
    nxt_mem_we = 1'b0;
    nxt_mem_wdata = mem_wdata_ff;
    skip = 1'b0;
    xres = work_ff ^ ISSUE_I.mem_data;
    // Fetch cycle: the word for the registered address is on PROG_DATA_I now
    if (fetch_ff) begin
      nxt_mem_we = 1'b1;
      nxt_mem_wdata = PROG_DATA_I[stxe_pkg::DATA_W-1:0];
      nxt_high = PROG_DATA_I[stxe_pkg::PROG_W-1:stxe_pkg::DATA_W];
    end
    if (issue_ok) begin
      unique case (ISSUE_I.op)
        stxe_pkg::STXE_OP_NIBBLE_EXCHANGE_TO_WORK:
          nxt_work = {ISSUE_I.mem_data[3:0], ISSUE_I.mem_data[7:4]};
        stxe_pkg::STXE_OP_SKIP_WHEN_NULL:
          skip = is_null(ISSUE_I.mem_data);
        stxe_pkg::STXE_OP_MOVE_SKIP_WHEN_NULL: begin
          nxt_work = ISSUE_I.mem_data;
          skip = is_null(ISSUE_I.mem_data);
        end
        stxe_pkg::STXE_OP_SKIP_BIT_NULL:
          skip = !ISSUE_I.mem_data[ISSUE_I.bit_sel];
        stxe_pkg::STXE_OP_TABLE_READ_CURRENT_PAGE,
        stxe_pkg::STXE_OP_TABLE_READ_LAST_PAGE:
          skip = 1'b0; // Address only; data moves in the fetch cycle
        stxe_pkg::STXE_OP_XOR_TO_WORK: begin
          nxt_work = xres;
          nxt_flags.zero = is_null(xres);
        end
        stxe_pkg::STXE_OP_BITWISE_DIFFERENCE_TO_MEMORY: begin
          nxt_mem_we = 1'b1;
          nxt_mem_wdata = xres;
          nxt_flags.zero = is_null(xres);
        end
        stxe_pkg::STXE_OP_XOR_IMMEDIATE: begin
          nxt_work = work_ff ^ ISSUE_I.imm;
          nxt_flags.zero = is_null(work_ff ^ ISSUE_I.imm);
        end
        default: skip = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      work_ff <= stxe_pkg::WORK_RST;
      high_ff <= stxe_pkg::HIGH_RST;
      flags_ff <= stxe_pkg::FLAGS_RST;
      mem_we_ff <= 1'b0;
      mem_wdata_ff <= '0;
    end else if (CE_I) begin
      work_ff <= nxt_work;
      high_ff <= nxt_high;
      flags_ff <= nxt_flags;
      mem_we_ff <= nxt_mem_we;
      mem_wdata_ff <= nxt_mem_wdata;
    end
  end

  // Sequencing group: dummy cycle after a taken skip, fetch cycle after a table read
  always_comb begin
    nxt_discard = 1'b0;
    nxt_fetch = 1'b0;
    if (issue_ok) begin
      nxt_discard = skip;
      nxt_fetch = is_table_read(ISSUE_I.op);
    end
    // Busy has its own flop so the output does not pass through a gate
    nxt_busy = nxt_discard || nxt_fetch;
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      discard_ff <= 1'b0;
      fetch_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else if (CE_I) begin
      discard_ff <= nxt_discard;
      fetch_ff <= nxt_fetch;
      busy_ff <= nxt_busy;
    end
  end

  // Every output is a flop; the price is the extra fetch cycle on table reads
  assign PROG_ADDR_O = prog_addr_ff;
  assign WORK_O = work_ff;
  assign TABLE_HIGH_LATCH_O = high_ff;
  assign FLAGS_O = flags_ff;
  assign MEM_WE_O = mem_we_ff;
  assign MEM_WDATA_O = mem_wdata_ff;
  assign DISCARD_O = discard_ff;
  assign BUSY_O = busy_ff;

  sequence null_skip_issue_s;
    issue_ok && CE_I && (ISSUE_I.op == stxe_pkg::STXE_OP_SKIP_WHEN_NULL)
      && is_null(ISSUE_I.mem_data);
  endsequence

  sequence dummy_cycle_s;
    discard_ff ##1 !discard_ff;
  endsequence

  // Multi-cycle checks assume CE_I stays high until the instruction completes
  sequence table_issue_s;
    issue_ok && CE_I && is_table_read(ISSUE_I.op);
  endsequence

  sequence table_fetch_s;
    fetch_ff && busy_ff && !discard_ff && !mem_we_ff && CE_I;
  endsequence

  null_skip_two_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    null_skip_issue_s |=> dummy_cycle_s)
    else $error("Null byte did not give one dummy cycle");

  no_skip_single_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (issue_ok && CE_I && ISSUE_I.op == stxe_pkg::STXE_OP_SKIP_WHEN_NULL
     && !is_null(ISSUE_I.mem_data)) |=> !discard_ff)
    else $error("Nonzero byte caused a skip");

  move_skip_work_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (issue_ok && CE_I && ISSUE_I.op == stxe_pkg::STXE_OP_MOVE_SKIP_WHEN_NULL)
    |=> (work_ff == $past(ISSUE_I.mem_data)) && (discard_ff == (work_ff == 8'h00)))
    else $error("Move-and-skip result wrong");

  bit_skip_sel_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (issue_ok && CE_I && ISSUE_I.op == stxe_pkg::STXE_OP_SKIP_BIT_NULL)
    |=> discard_ff == !$past(ISSUE_I.mem_data[ISSUE_I.bit_sel]))
    else $error("Bit skip decision wrong");

  nibble_swap_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (issue_ok && CE_I && ISSUE_I.op == stxe_pkg::STXE_OP_NIBBLE_EXCHANGE_TO_WORK)
    |=> work_ff == {$past(ISSUE_I.mem_data[3:0]), $past(ISSUE_I.mem_data[7:4])}
        && !mem_we_ff)
    else $error("Nibble exchange wrong");

  table_high_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    table_issue_s ##1 table_fetch_s
    |=> mem_we_ff && high_ff == $past(PROG_DATA_I[14:8])
        && mem_wdata_ff == $past(PROG_DATA_I[7:0]))
    else $error("Table read split wrong");

  last_page_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (issue_ok && CE_I && ISSUE_I.op == stxe_pkg::STXE_OP_TABLE_READ_LAST_PAGE)
    |=> prog_addr_ff == {4'hf, $past(TABLE_POINTER_I)})
    else $error("Last page address wrong");

  xor_memory_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (issue_ok && CE_I && ISSUE_I.op == stxe_pkg::STXE_OP_BITWISE_DIFFERENCE_TO_MEMORY)
    |=> mem_we_ff && work_ff == $past(work_ff)
        && mem_wdata_ff == ($past(work_ff) ^ $past(ISSUE_I.mem_data)))
    else $error("Xor to memory wrong");

  xor_flags_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (issue_ok && CE_I && ISSUE_I.op == stxe_pkg::STXE_OP_XOR_IMMEDIATE)
    |=> flags_ff.zero == (work_ff == 8'h00) && flags_ff.carry == $past(flags_ff.carry)
        && flags_ff.overflow == $past(flags_ff.overflow))
    else $error("Xor flag update wrong");

  keep_flags_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (issue_ok && CE_I && (ISSUE_I.op == stxe_pkg::STXE_OP_SKIP_WHEN_NULL
     || ISSUE_I.op == stxe_pkg::STXE_OP_TABLE_READ_CURRENT_PAGE))
    |=> $stable(flags_ff))
    else $error("Flags changed by skip or table read");

  current_page_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (issue_ok && CE_I && ISSUE_I.op == stxe_pkg::STXE_OP_TABLE_READ_CURRENT_PAGE)
    |=> prog_addr_ff == {$past(ISSUE_I.pc[11:8]), $past(TABLE_POINTER_I)} && fetch_ff)
    else $error("Current page address wrong");

  fetch_once_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    table_fetch_s |=> !fetch_ff && !busy_ff && $stable(prog_addr_ff))
    else $error("Table fetch did not end after one cycle");

  high_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !fetch_ff |=> $stable(high_ff))
    else $error("High latch moved outside a table fetch");

  xor_work_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (issue_ok && CE_I && ISSUE_I.op == stxe_pkg::STXE_OP_XOR_TO_WORK)
    |=> work_ff == ($past(work_ff) ^ $past(ISSUE_I.mem_data)) && !mem_we_ff)
    else $error("Xor into work wrong");

  xor_imm_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (issue_ok && CE_I && ISSUE_I.op == stxe_pkg::STXE_OP_XOR_IMMEDIATE)
    |=> work_ff == ($past(work_ff) ^ $past(ISSUE_I.imm)) && !mem_we_ff)
    else $error("Xor with immediate wrong");

  prefetch_drop_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (discard_ff && CE_I) |=> $stable(work_ff) && $stable(flags_ff) && !mem_we_ff
        && !busy_ff)
    else $error("Discarded prefetch was executed");

  skip_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (issue_ok && CE_I && ISSUE_I.op == stxe_pkg::STXE_OP_SKIP_WHEN_NULL)
    |=> $stable(work_ff) && !mem_we_ff && !fetch_ff)
    else $error("Skip instruction moved data");

  table_flags_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    table_issue_s |=> $stable(flags_ff) ##1 $stable(flags_ff))
    else $error("Flags changed during table read");

  other_flags_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (issue_ok && CE_I && (ISSUE_I.op == stxe_pkg::STXE_OP_MOVE_SKIP_WHEN_NULL
     || ISSUE_I.op == stxe_pkg::STXE_OP_SKIP_BIT_NULL
     || ISSUE_I.op == stxe_pkg::STXE_OP_NIBBLE_EXCHANGE_TO_WORK))
    |=> $stable(flags_ff))
    else $error("Flags changed by move, bit skip or exchange");

  invalid_op_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (issue_ok && CE_I && ISSUE_I.op == stxe_pkg::STXE_OP_NONE)
    |=> $stable(work_ff) && $stable(flags_ff) && !mem_we_ff && !busy_ff)
    else $error("Empty operation changed state");

  freeze_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !CE_I |=> $stable(work_ff) && $stable(flags_ff) && $stable(mem_we_ff)
        && $stable(busy_ff) && $stable(prog_addr_ff))
    else $error("State moved while clock enable was low");

  reset_clear_a: assert property (@(posedge CLK_I)
    !RST_N_I |=> work_ff == stxe_pkg::WORK_RST && flags_ff == stxe_pkg::FLAGS_RST
        && !mem_we_ff && !busy_ff && !discard_ff)
    else $error("Reset did not clear the state");

endmodule // stxe_exec

// File: sim/tb_top.sv
// Self-checking bench for the null-skip, table-read and exclusive-or execute unit.
// Assumes the unit's ports as declared; the bench plays issuing core and program memory.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic valid = 1'b0;
  stxe_pkg::stxe_issue_s iss_d = '0;
  logic [7:0] tbl_ptr = 8'h00;
  logic [14:0] prog = 15'h0000;
  logic [11:0] prog_addr;
  logic [7:0] work;
  logic [6:0] high;
  stxe_pkg::stxe_flags_s flags;
  logic mem_we;
  logic discard;
  logic busy;
  logic [7:0] wdata;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  stxe_exec stxe_exec_i (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .ISSUE_VALID_I(valid),
    .ISSUE_I(iss_d), .TABLE_POINTER_I(tbl_ptr), .PROG_DATA_I(prog), .PROG_ADDR_O(prog_addr),
    .WORK_O(work), .TABLE_HIGH_LATCH_O(high), .FLAGS_O(flags), .MEM_WE_O(mem_we),
    .MEM_WDATA_O(wdata), .DISCARD_O(discard), .BUSY_O(busy));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Work, write strobe, dummy cycle (both views) and the whole flag set in one go
  task automatic st(input logic [7:0] w, input logic we, input logic d, input logic z);
    chk({work, mem_we, discard, busy, flags}, {w, we, d, d, 3'b000, z, 2'b00});
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Inputs change only at the falling edge; outputs are read one falling edge later
  task automatic issue(input stxe_pkg::stxe_op_e op, input logic [7:0] m,
                       input logic [7:0] imm, input logic [2:0] b, input logic [11:0] pc);
    iss_d = '{op: op, mem_data: m, imm: imm, bit_sel: b, pc: pc};
    valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic idle();
    valid = 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic t_xor();
    issue(stxe_pkg::STXE_OP_XOR_IMMEDIATE, 8'h00, 8'h5a, 3'h0, 12'h000);
    st(8'h5a, 1'b0, 1'b0, 1'b0);
    issue(stxe_pkg::STXE_OP_XOR_TO_WORK, 8'h5a, 8'h00, 3'h0, 12'h000);
    st(8'h00, 1'b0, 1'b0, 1'b1);
    issue(stxe_pkg::STXE_OP_BITWISE_DIFFERENCE_TO_MEMORY, 8'h0f, 8'h00, 3'h0, 12'h000);
    st(8'h00, 1'b1, 1'b0, 1'b0);
    chk({24'h0, wdata}, 32'h0000000f);
    issue(stxe_pkg::STXE_OP_BITWISE_DIFFERENCE_TO_MEMORY, 8'h00, 8'h00, 3'h0, 12'h000);
    st(8'h00, 1'b1, 1'b0, 1'b1);
    $display("xor test done");
  endtask

  // Zero flag is left set on purpose so that a stray flag update shows
  task automatic t_skip();
    issue(stxe_pkg::STXE_OP_NIBBLE_EXCHANGE_TO_WORK, 8'h3c, 8'h00, 3'h0, 12'h000);
    st(8'hc3, 1'b0, 1'b0, 1'b1);
    issue(stxe_pkg::STXE_OP_SKIP_WHEN_NULL, 8'h00, 8'h00, 3'h0, 12'h000);
    st(8'hc3, 1'b0, 1'b1, 1'b1);
    issue(stxe_pkg::STXE_OP_XOR_IMMEDIATE, 8'h00, 8'hff, 3'h0, 12'h000);
    st(8'hc3, 1'b0, 1'b0, 1'b1);
    issue(stxe_pkg::STXE_OP_SKIP_WHEN_NULL, 8'h01, 8'h00, 3'h0, 12'h000);
    st(8'hc3, 1'b0, 1'b0, 1'b1);
    issue(stxe_pkg::STXE_OP_MOVE_SKIP_WHEN_NULL, 8'h00, 8'h00, 3'h0, 12'h000);
    st(8'h00, 1'b0, 1'b1, 1'b1);
    issue(stxe_pkg::STXE_OP_XOR_IMMEDIATE, 8'h00, 8'hff, 3'h0, 12'h000);
    st(8'h00, 1'b0, 1'b0, 1'b1);
    issue(stxe_pkg::STXE_OP_MOVE_SKIP_WHEN_NULL, 8'h80, 8'h00, 3'h0, 12'h000);
    st(8'h80, 1'b0, 1'b0, 1'b1);
    issue(stxe_pkg::STXE_OP_SKIP_BIT_NULL, 8'hf7, 8'h00, 3'h3, 12'h000);
    st(8'h80, 1'b0, 1'b1, 1'b1);
    idle();
    issue(stxe_pkg::STXE_OP_SKIP_BIT_NULL, 8'h08, 8'h00, 3'h3, 12'h000);
    st(8'h80, 1'b0, 1'b0, 1'b1);
    $display("skip test done");
  endtask

  // Bench plays program memory: it answers the registered address in the fetch cycle
  task automatic t_table();
    tbl_ptr = 8'h42;
    issue(stxe_pkg::STXE_OP_TABLE_READ_CURRENT_PAGE, 8'h00, 8'h00, 3'h0, 12'h3a5);
    chk({17'h0, prog_addr, mem_we, discard, busy}, {17'h0, 12'h342, 3'b001});
    prog = 15'h2a96;
    idle();
    st(8'h80, 1'b1, 1'b0, 1'b1);
    chk({5'h0, prog_addr, high, wdata}, {5'h0, 12'h342, 7'h2a, 8'h96});
    tbl_ptr = 8'hff;
    issue(stxe_pkg::STXE_OP_TABLE_READ_LAST_PAGE, 8'h00, 8'h00, 3'h0, 12'h3a5);
    chk({17'h0, prog_addr, mem_we, discard, busy}, {17'h0, 12'hfff, 3'b001});
    prog = 15'h7f01;
    // An issue during the fetch cycle must not be taken
    issue(stxe_pkg::STXE_OP_XOR_IMMEDIATE, 8'h00, 8'hff, 3'h0, 12'h000);
    st(8'h80, 1'b1, 1'b0, 1'b1);
    chk({5'h0, prog_addr, high, wdata}, {5'h0, 12'hfff, 7'h7f, 8'h01});
    ce = 1'b0;
    issue(stxe_pkg::STXE_OP_XOR_IMMEDIATE, 8'h00, 8'hff, 3'h0, 12'h000);
    chk({18'h0, work, flags}, {18'h0, 8'h80, 6'h04});
    ce = 1'b1;
    idle();
    issue(stxe_pkg::STXE_OP_NONE, 8'h00, 8'hff, 3'h0, 12'h000);
    st(8'h80, 1'b0, 1'b0, 1'b1);
    $display("table test done");
  endtask

  // Tests need well under a hundred cycles; the ceiling only catches a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 500) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    st(8'h00, 1'b0, 1'b0, 1'b0);
    t_xor();
    t_skip();
    t_table();
    tally_and_finish();
  end
endmodule // tb_top
